// ### core/ebps_pkg.sv
// Purpose: Shared constants and types for the external bus pin select.
// Assumes: One 32-bit select register at a byte address on a plain port.
// Notes:   Pin vector packs port 2, then port 3, then port 1 pins.
package ebps_pkg;

	// Register map
	localparam logic [31:0] REG_ADDR   = 32'hE002C014;
	localparam logic [31:0] SEL_RST    = 32'h006000C0;
	localparam logic [31:0] WRITE_MASK = 32'h0FF3E9F0;

	// Field positions
	localparam int F_BUSW     = 4;
	localparam int F_ANALOG_INPUT_SIX     = 6;
	localparam int F_ANALOG_INPUT_SEVEN     = 7;
	localparam int F_WSTROBE  = 8;
	localparam int F_BANK1    = 11;
	localparam int F_EXTERNAL_CLOCK_OUTPUT     = 13;
	localparam int F_BANK2    = 14;
	localparam int F_BANK3    = 16;
	localparam int F_D2928    = 20;
	localparam int F_ANALOG_INPUT_FOUR     = 21;
	localparam int F_ANALOG_INPUT_FIVE     = 22;
	localparam int F_ADDR0    = 23;
	localparam int F_ADDR1    = 24;
	localparam int F_ADDRCNT  = 25;

	// Bus-width codes
	localparam logic [1:0] BUSW_8    = 2'h0;
	localparam logic [1:0] BUSW_16   = 2'h1;
	localparam logic [1:0] BUSW_32   = 2'h2;
	localparam logic [1:0] BUSW_NONE = 2'h3;

	// Bank select codes, others reserved
	localparam logic [1:0] BANK_PORT = 2'h0;
	localparam logic [1:0] BANK_CHIP = 2'h1;

	// Address-line-count codes
	localparam logic [2:0] ADDR_NONE = 3'h0;
	localparam logic [2:0] ADDR_FULL = 3'h7;
	localparam int         ADDR_W    = 22;

	// Strap codes
	localparam logic [1:0] BOOT_ADDR0 = 2'h0;
	localparam logic [1:0] BOOT_NOEXT = 2'h3;

	// Pin vector layout
	localparam int PIN_COUNT   = 66;
	localparam int PIN_P2_BASE = 0;
	localparam int PIN_P3_BASE = 32;
	localparam int PIN_P1_BASE = 64;
	localparam int PORT_W      = 32;
	localparam int P1_W        = 2;
	localparam int P2_ANALOG_INPUT_FOUR     = 30;
	localparam int P2_ANALOG_INPUT_FIVE     = 31;
	localparam int P3_ADDR_LO  = 2;
	localparam int P3_A23      = 23;
	localparam int P3_BANK3    = 24;
	localparam int P3_BANK2    = 25;
	localparam int P3_BANK1    = 26;
	localparam int P3_WSTROBE  = 27;
	localparam int P3_LANE3    = 28;
	localparam int P3_LANE2    = 29;
	localparam int P3_LANE1    = 30;
	localparam int P3_LANE0    = 31;

	typedef enum logic [1:0] {
		LD_SYNC1 = 2'b00,
		LD_SYNC2 = 2'b01,
		LD_LOAD  = 2'b10,
		LD_RUN   = 2'b11
	} ebps_ld_e;

	typedef struct packed {
		logic                  low_bus;
		logic                  mid_bus;
		logic                  up_bus;
		logic                  analog_input_four;
		logic                  analog_input_five;
		logic                  analog_input_six;
		logic                  analog_input_seven;
		logic                  wstrobe;
		logic                  bank1;
		logic                  bank2;
		logic                  bank3;
		logic                  external_clock_output;
		logic                  addr0;
		logic                  addr1;
		logic [ADDR_W-1:0]     addr;
		logic [PIN_COUNT-1:0]  is_port;
	} ebps_pins_s;

	// Address mask for EXTERNAL_ADDRESS_LINES from the line-count code
	function automatic logic [ADDR_W-1:0] addr_mask(input logic [2:0] code);
		logic [ADDR_W-1:0] m;
		m = '0;
		case (code)
			3'h1:    m = 22'h000003;
			3'h2:    m = 22'h00000F;
			3'h3:    m = 22'h00003F;
			3'h4:    m = 22'h0003FF;
			3'h5:    m = 22'h003FFF;
			3'h6:    m = 22'h03FFFF;
			3'h7:    m = 22'h3FFFFF;
			default: m = '0;
		endcase
		return m;
	endfunction : addr_mask

endpackage : ebps_pkg

// ### core/ebps_dir_mux.sv
// Purpose: Per-pin direction select between port and function control.
// Assumes: All inputs come from logic on the same clock.
// Notes:   Direction 1 drives the pin; the result is registered.
`timescale 1ns/1ps
module ebps_dir_mux (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// Selection and direction sources
	input  wire logic [ebps_pkg::PIN_COUNT-1:0] port_sel,
	input  wire logic [ebps_pkg::PIN_COUNT-1:0] gpio_dir,
	input  wire logic [ebps_pkg::PIN_COUNT-1:0] func_dir,
	// Resolved direction
	output logic      [ebps_pkg::PIN_COUNT-1:0] pin_dir
);

	typedef struct packed {
		logic [ebps_pkg::PIN_COUNT-1:0] dir;
	} ebps_dir_s;

	ebps_dir_s s_r;
	ebps_dir_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		// Port bit only counts while the port function owns the pin
		s_nxt.dir = (port_sel & gpio_dir) | (~port_sel & func_dir);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin_dir = s_r.dir;

endmodule : ebps_dir_mux

// ### core/ebps_top.sv
// Purpose: External bus pin function select register and pin decode.
// Assumes: Strap pins are asynchronous and held steady around reset.
// Notes:   All pins stay port pins, directed by the port register, until the straps have been loaded.
//
// Summary of operation
// - Bus width strap-reset; 11 gives low pins port
// - Upper data and lanes 2-3 only at 10
// - Bits 6,7,21,22 pick port or analog inputs
// - Bit 8 write strobe, bit 11 bank1 select
// - Bit 13 picks clock output unless full address
// - Bank2/3 fields: 00 port, 01 select, others reserved
// - Bits 23,24 make address lines 0,1 from straps
// - Field 27:25 sets address line count from straps
// - Port direction applies only to port-owned pins
`timescale 1ns/1ps
module ebps_top (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// Register port
	input  wire logic [31:0]                    addr,
	input  wire logic [31:0]                    wdata,
	input  wire logic                           wr,
	input  wire logic                           rd,
	output logic      [31:0]                    rdata,
	// Strap pins
	input  wire logic [1:0]                     boot_strap_pins,
	// Direction sources
	input  wire logic [ebps_pkg::PIN_COUNT-1:0] port_direction_register,
	input  wire logic                           mem_data_drive,
	// Function enables
	output logic                                low_byte_bus_en,
	output logic                                mid_byte_bus_en,
	output logic                                upper_bus_en,
	output logic                                analog_input_four_en,
	output logic                                analog_input_five_en,
	output logic                                analog_input_six_en,
	output logic                                analog_input_seven_en,
	output logic                                write_strobe_en,
	output logic                                bank1_chip_select_en,
	output logic                                bank2_chip_select_en,
	output logic                                bank3_chip_select_en,
	output logic                                external_clock_output_en,
	output logic                                addr_line0_en,
	output logic                                addr_line1_en,
	output logic [ebps_pkg::ADDR_W-1:0]         external_address_lines_en,
	// Pin ownership and direction
	output logic [ebps_pkg::PIN_COUNT-1:0]      pin_is_port,
	output logic [ebps_pkg::PIN_COUNT-1:0]      pin_dir,
	// Status
	output logic                                strap_loaded
);

	typedef struct packed {
		ebps_pkg::ebps_ld_e  state;
		logic [1:0]          sync1;
		logic [1:0]          sync2;
		logic [31:0]         sel;
		logic [31:0]         rdata;
		logic                loaded;
		ebps_pkg::ebps_pins_s pins;
	} ebps_state_s;

	ebps_state_s                    s_r;
	ebps_state_s                    s_nxt;
	logic [ebps_pkg::PIN_COUNT-1:0] func_dir;
	logic                           reg_sel;

	// Bank select field; reserved codes keep the pin a port pin
	function automatic logic bank_sel(input logic [1:0] code);
		logic on;
		on = 1'b0;
		case (code)
			ebps_pkg::BANK_PORT: begin
				on = 1'b0;
			end
			ebps_pkg::BANK_CHIP: begin
				on = 1'b1;
			end
			default: begin
				on = 1'b0;
			end
		endcase
		return on;
	endfunction : bank_sel

	// Decode the select word into function enables and pin ownership
	function automatic ebps_pkg::ebps_pins_s decode(input logic [31:0] v);
		ebps_pkg::ebps_pins_s p;
		logic [1:0]           busw;
		logic [2:0]           acnt;
		p    = '0;
		busw = v[ebps_pkg::F_BUSW +: 2];
		acnt = v[ebps_pkg::F_ADDRCNT +: 3];
		// Wider buses include the narrower lanes
		case (busw)
			ebps_pkg::BUSW_8: begin
				p.low_bus = 1'b1;
			end
			ebps_pkg::BUSW_16: begin
				p.low_bus = 1'b1;
				p.mid_bus = 1'b1;
			end
			ebps_pkg::BUSW_32: begin
				p.low_bus = 1'b1;
				p.mid_bus = 1'b1;
				p.up_bus  = 1'b1;
			end
			ebps_pkg::BUSW_NONE: begin
				p.low_bus = 1'b0;
			end
			default: begin
				p.low_bus = 1'b0;
			end
		endcase
		// Analog pins follow their bits only off the 32-bit bus
		p.analog_input_four = !p.up_bus && v[ebps_pkg::F_ANALOG_INPUT_FOUR];
		p.analog_input_five = !p.up_bus && v[ebps_pkg::F_ANALOG_INPUT_FIVE];
		p.analog_input_six = !p.up_bus && v[ebps_pkg::F_ANALOG_INPUT_SIX];
		p.analog_input_seven = !p.up_bus && v[ebps_pkg::F_ANALOG_INPUT_SEVEN];
		p.wstrobe = v[ebps_pkg::F_WSTROBE];
		p.bank1   = v[ebps_pkg::F_BANK1];
		// Reserved bank codes leave the pin with the port
		p.bank2 = bank_sel(v[ebps_pkg::F_BANK2 +: 2]);
		p.bank3 = bank_sel(v[ebps_pkg::F_BANK3 +: 2]);
		p.addr  = ebps_pkg::addr_mask(acnt);
		p.external_clock_output  = (acnt != ebps_pkg::ADDR_FULL) && v[ebps_pkg::F_EXTERNAL_CLOCK_OUTPUT];
		p.addr0 = v[ebps_pkg::F_ADDR0];
		p.addr1 = v[ebps_pkg::F_ADDR1];

		// Port 2: data lanes and analog inputs
		p.is_port[ebps_pkg::PIN_P2_BASE +: 8] = {8{!p.low_bus}};
		p.is_port[ebps_pkg::PIN_P2_BASE + 8 +: 8] = {8{!p.mid_bus}};
		// Lines 29:28 stay port off the 32-bit bus; bit 20 high is reserved
		p.is_port[ebps_pkg::PIN_P2_BASE + 16 +: 14] = {14{!p.up_bus}};
		p.is_port[ebps_pkg::PIN_P2_BASE + ebps_pkg::P2_ANALOG_INPUT_FOUR] =
			!p.up_bus && !p.analog_input_four;
		p.is_port[ebps_pkg::PIN_P2_BASE + ebps_pkg::P2_ANALOG_INPUT_FIVE] =
			!p.up_bus && !p.analog_input_five;

		// Port 3: address, strobes and selects
		p.is_port[ebps_pkg::PIN_P3_BASE] = !p.addr0;
		p.is_port[ebps_pkg::PIN_P3_BASE + 1] = !p.addr1;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_ADDR_LO +: 21] =
			~p.addr[20:0];
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_A23] =
			!p.addr[ebps_pkg::ADDR_W-1] && !p.external_clock_output;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_BANK3] =
			!p.bank3;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_BANK2] =
			!p.bank2;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_BANK1] =
			!p.bank1;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_WSTROBE] =
			!p.wstrobe;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_LANE3] =
			!p.up_bus && !p.analog_input_seven;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_LANE2] =
			!p.up_bus && !p.analog_input_six;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_LANE1] =
			!p.mid_bus;
		p.is_port[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_LANE0] =
			!p.low_bus;

		// Port 1: bank0 select and output strobe
		p.is_port[ebps_pkg::PIN_P1_BASE +: ebps_pkg::P1_W] =
			{ebps_pkg::P1_W{!p.low_bus}};
		return p;
	endfunction : decode

	// Apply strap values to the strap-dependent fields
	function automatic logic [31:0] strap_apply(input logic [31:0] v,
		input logic [1:0] boot);
		logic [31:0] r;
		r = v;
		r[ebps_pkg::F_BUSW +: 2] = boot;
		r[ebps_pkg::F_ADDR0] = (boot == ebps_pkg::BOOT_ADDR0);
		r[ebps_pkg::F_ADDR1] = boot[1];
		r[ebps_pkg::F_ADDRCNT +: 3] = (boot == ebps_pkg::BOOT_NOEXT) ?
			ebps_pkg::ADDR_NONE : ebps_pkg::ADDR_FULL;
		return r;
	endfunction : strap_apply

	// The register answers at one address only
	assign reg_sel = (addr == ebps_pkg::REG_ADDR);

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = boot_strap_pins;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.rdata = '0;

		case (s_r.state)
			ebps_pkg::LD_SYNC1: begin
				s_nxt.state = ebps_pkg::LD_SYNC2;
			end
			ebps_pkg::LD_SYNC2: begin
				s_nxt.state = ebps_pkg::LD_LOAD;
			end
			ebps_pkg::LD_LOAD: begin
				s_nxt.sel   = strap_apply(s_r.sel, s_r.sync2);
				s_nxt.state = ebps_pkg::LD_RUN;
			end
			ebps_pkg::LD_RUN: begin
				s_nxt.state = ebps_pkg::LD_RUN;
			end
			default: begin
				s_nxt.state = ebps_pkg::LD_SYNC1;
			end
		endcase

		// A write in the strap-load cycle takes precedence
		if (wr && reg_sel) begin
			s_nxt.sel = wdata & ebps_pkg::WRITE_MASK;
		end

		// Read data stand for the one cycle after the strobe
		if (rd && reg_sel) begin
			s_nxt.rdata = s_r.sel & ebps_pkg::WRITE_MASK;
		end

		// Status kept in a flop of its own
		s_nxt.loaded = (s_nxt.state == ebps_pkg::LD_RUN);

		// Everything stays a port pin, direction from the port register, until the straps are in
		if (s_nxt.state == ebps_pkg::LD_RUN) begin
			s_nxt.pins = decode(s_nxt.sel);
		end else begin
			s_nxt.pins = '0;
			s_nxt.pins.is_port = '1;
		end
	end

	// Straps are taken once after each reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_r.state <= ebps_pkg::LD_SYNC1;
			s_r.sync1 <= '0;
			s_r.sync2 <= '0;
			s_r.sel   <= ebps_pkg::SEL_RST;
			s_r.rdata <= '0;
			s_r.loaded <= 1'b0;
			s_r.pins  <= '0;
			s_r.pins.is_port <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Directions for pins owned by a function
	always_comb begin
		func_dir = '1;
		// Address, strobe and select pins always drive
		func_dir[ebps_pkg::PIN_P3_BASE +: ebps_pkg::PORT_W] =
			{ebps_pkg::PORT_W{1'b1}};
		func_dir[ebps_pkg::PIN_P1_BASE +: ebps_pkg::P1_W] =
			{ebps_pkg::P1_W{1'b1}};
		// Data lanes follow the memory controller's drive
		func_dir[ebps_pkg::PIN_P2_BASE +: ebps_pkg::PORT_W] =
			{ebps_pkg::PORT_W{mem_data_drive}};
		// Analog inputs never drive
		func_dir[ebps_pkg::PIN_P2_BASE + ebps_pkg::P2_ANALOG_INPUT_FOUR] =
			mem_data_drive && s_r.pins.up_bus;
		func_dir[ebps_pkg::PIN_P2_BASE + ebps_pkg::P2_ANALOG_INPUT_FIVE] =
			mem_data_drive && s_r.pins.up_bus;
		func_dir[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_LANE3] =
			s_r.pins.up_bus;
		func_dir[ebps_pkg::PIN_P3_BASE + ebps_pkg::P3_LANE2] =
			s_r.pins.up_bus;
	end

	ebps_dir_mux u_dir (
		.clock    (clock),
		.rst_n    (rst_n),
		.port_sel (s_r.pins.is_port),
		.gpio_dir (port_direction_register),
		.func_dir (func_dir),
		.pin_dir  (pin_dir)
	);

	assign rdata                     = s_r.rdata;
	assign low_byte_bus_en           = s_r.pins.low_bus;
	assign mid_byte_bus_en           = s_r.pins.mid_bus;
	assign upper_bus_en              = s_r.pins.up_bus;
	assign analog_input_four_en      = s_r.pins.analog_input_four;
	assign analog_input_five_en      = s_r.pins.analog_input_five;
	assign analog_input_six_en       = s_r.pins.analog_input_six;
	assign analog_input_seven_en     = s_r.pins.analog_input_seven;
	assign write_strobe_en           = s_r.pins.wstrobe;
	assign bank1_chip_select_en      = s_r.pins.bank1;
	assign bank2_chip_select_en      = s_r.pins.bank2;
	assign bank3_chip_select_en      = s_r.pins.bank3;
	assign external_clock_output_en  = s_r.pins.external_clock_output;
	assign addr_line0_en             = s_r.pins.addr0;
	assign addr_line1_en             = s_r.pins.addr1;
	assign external_address_lines_en = s_r.pins.addr;
	assign pin_is_port               = s_r.pins.is_port;
	assign strap_loaded              = s_r.loaded;

endmodule : ebps_top

// ### dv/ebps_far_model.sv
// Purpose: Board and memory controller side feeding pin directions.
// Assumes: Bench sets the wanted directions and data drive each cycle.
// Notes:   Outputs are registered like the real GPIO and controller.
`timescale 1ns/1ps
module ebps_far_model (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// Bench commands
	input  wire logic [ebps_pkg::PIN_COUNT-1:0] dir_set,
	input  wire logic                           drive_set,
	// Board side
	output logic      [ebps_pkg::PIN_COUNT-1:0] port_direction_register,
	output logic                                mem_data_drive
);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			port_direction_register <= '0;
			mem_data_drive          <= 1'b0;
		end else begin
			port_direction_register <= dir_set;
			mem_data_drive          <= drive_set;
		end
	end
endmodule : ebps_far_model

// ### dv/ebps_assertions.sv
// Purpose: Port checks for the external bus pin select.
// Assumes: Straps held steady around reset.
// Notes:   Bound into every ebps_top.
`timescale 1ns/1ps
module ebps_checker (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  boot_strap_pins,
	input wire logic [65:0] port_direction_register,
	input wire logic        mem_data_drive,
	input wire logic        low_byte_bus_en,
	input wire logic        mid_byte_bus_en,
	input wire logic        upper_bus_en,
	input wire logic        analog_input_four_en,
	input wire logic        analog_input_five_en,
	input wire logic        analog_input_six_en,
	input wire logic        analog_input_seven_en,
	input wire logic        write_strobe_en,
	input wire logic        bank1_chip_select_en,
	input wire logic        bank2_chip_select_en,
	input wire logic        bank3_chip_select_en,
	input wire logic        external_clock_output_en,
	input wire logic        addr_line0_en,
	input wire logic        addr_line1_en,
	input wire logic [21:0] external_address_lines_en,
	input wire logic [65:0] pin_is_port,
	input wire logic [65:0] pin_dir,
	input wire logic        strap_loaded
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic hit;
	assign hit = wr && addr == ebps_pkg::REG_ADDR && strap_loaded;
	a_rd_idle: assert property (!rd |=> rdata == 32'h0)
		else $error("read data without a read");
	a_rsvd_zero: assert property (rd |=> (rdata & 32'hF00C160F) == 32'h0)
		else $error("reserved bits read nonzero");
	a_width_nest: assert property (low_byte_bus_en >= mid_byte_bus_en
		&& mid_byte_bus_en >= upper_bus_en)
		else $error("bus lanes out of order");
	a_ain_follow: assert property (hit |=> analog_input_six_en ==
		($past(wdata[6]) && $past(wdata[5:4]) != 2'h2))
		else $error("analog select wrong");
	a_wr_decode: assert property (hit |=> write_strobe_en == $past(wdata[8])
		&& bank1_chip_select_en == $past(wdata[11]))
		else $error("strobe or bank1 select wrong");
	a_bank_code: assert property (hit |=> bank3_chip_select_en ==
		($past(wdata[17:16]) == 2'h1))
		else $error("bank3 select wrong");
	a_external_clock_output_full: assert property (hit |=> external_clock_output_en ==
		($past(wdata[13]) && $past(wdata[27:25]) != 3'h7))
		else $error("clock output wrong");
	a_addr_low: assert property (hit |=> addr_line0_en == $past(wdata[23])
		&& addr_line1_en == $past(wdata[24]))
		else $error("address line 0 or 1 wrong");
	a_addr_shape: assert property (external_address_lines_en inside {22'h0,
		22'h3, 22'hF, 22'h3F, 22'h3FF, 22'h3FFF, 22'h3FFFF, 22'h3FFFFF})
		else $error("address line set not contiguous");
	a_dir_port: assert property (1 |=> ((pin_dir ^ $past(port_direction_register))
		& $past(pin_is_port)) == '0)
		else $error("port pin direction ignored");
	a_strap_load: assert property ($rose(strap_loaded) && !$past(wr)
		|-> addr_line1_en ==
		$past(boot_strap_pins[1], 3))
		else $error("strap not applied");
	cover property (hit && wdata[5:4] == 2'h2);
	cover property ($rose(strap_loaded));
	cover property (rd ##1 rdata != 32'h0);
endmodule : ebps_checker
bind ebps_top ebps_checker u_ebps_checker (.*);

// ### dv/tb.sv
// Purpose: Register level tests of the external bus pin select.
// Assumes: One clock at 20 MHz, straps steady through each reset.
// Notes:   Each strap code is applied through its own reset.
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] RA = ebps_pkg::REG_ADDR;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [1:0]  boot_strap_pins = 2'h0;
	logic [65:0] dir_set = 66'h00FF;
	logic        drive_set = 1'b0;
	logic [31:0] rdata, e;
	logic [65:0] port_direction_register, pin_is_port, pin_dir;
	logic        mem_data_drive, low_byte_bus_en, mid_byte_bus_en;
	logic        upper_bus_en, analog_input_four_en, analog_input_five_en;
	logic        analog_input_six_en, analog_input_seven_en;
	logic        write_strobe_en, bank1_chip_select_en, bank2_chip_select_en;
	logic        bank3_chip_select_en, external_clock_output_en;
	logic        addr_line0_en, addr_line1_en, strap_loaded;
	logic [21:0] external_address_lines_en;
	logic [21:0] am [8] = '{22'h0, 22'h3, 22'hF, 22'h3F, 22'h3FF, 22'h3FFF,
		22'h3FFFF, 22'h3FFFFF};
	logic [1:0]  bb;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	ebps_top u_ebps_top (.*);
	ebps_far_model u_ebps_far_model (.clock(clock), .rst_n(rst_n),
		.dir_set(dir_set), .drive_set(drive_set),
		.port_direction_register(port_direction_register),
		.mem_data_drive(mem_data_drive));
	always #25 clock = ~clock;
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr    <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd   <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_chk
	task automatic do_reset(input logic [1:0] b);
		@(posedge clock);
		rst_n           <= 1'b0;
		boot_strap_pins <= b;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
	endtask : do_reset
	initial begin
		for (int b = 0; b < 4; b++) begin
			bb = 2'(b);
			do_reset(bb);
			e = ebps_pkg::SEL_RST | {4'h0, (bb == 2'h3) ? 3'h0 : 3'h7, bb[1],
				bb == 2'h0, 17'h0, bb, 4'h0};
			rd_chk(RA, e);
			chk(32'(strap_loaded), 32'h1);
			chk(32'(low_byte_bus_en), 32'(bb != 2'h3));
			chk(32'({analog_input_four_en, analog_input_five_en,
				analog_input_six_en, analog_input_seven_en}),
				(bb == 2'h2) ? 32'h0 : 32'hF);
			chk(32'(external_address_lines_en),
				(bb == 2'h3) ? 32'h0 : 32'h3FFFFF);
			chk(32'({addr_line0_en, addr_line1_en}),
				32'({bb == 2'h0, bb[1]}));
			chk(32'({write_strobe_en, bank1_chip_select_en, bank2_chip_select_en,
				bank3_chip_select_en, external_clock_output_en}), 32'h0);
		end
		$display("test strap reset done");
		for (int w = 0; w < 4; w++) begin
			bb = 2'(w);
			wr_reg(RA, 32'h006000C0 | {26'h0, bb, 4'h0});
			chk(32'({low_byte_bus_en, mid_byte_bus_en, upper_bus_en}),
				32'({bb != 2'h3, bb == 2'h1 || bb == 2'h2, bb == 2'h2}));
			chk(32'({analog_input_four_en, analog_input_six_en}),
				(bb == 2'h2) ? 32'h0 : 32'h3);
			chk(pin_is_port[31:0], {2'b00, {14{bb != 2'h2}},
				{8{bb == 2'h0 || bb == 2'h3}}, {8{bb == 2'h3}}});
		end
		$display("test bus width done");
		for (int c = 0; c < 8; c++) begin
			bb = 2'(c);
			e = {4'h0, 3'(c), bb[1], bb[0], 5'h0, 1'b0, bb[0], 1'b0, bb[0],
				1'b1, 1'b0, bb[1], 2'h0, bb[0], 8'h0};
			wr_reg(RA, e);
			chk(32'(external_address_lines_en), 32'(am[c]));
			chk(32'(external_clock_output_en), 32'(c != 7));
			chk(32'({addr_line0_en, addr_line1_en}), 32'({bb[0], bb[1]}));
			chk(32'({write_strobe_en, bank1_chip_select_en}),
				32'({bb[0], bb[1]}));
			chk(32'({bank2_chip_select_en, bank3_chip_select_en,
				pin_is_port[32 + ebps_pkg::P3_BANK2]}),
				bb[0] ? 32'h6 : 32'h1);
			rd_chk(RA, e);
		end
		$display("test field codes done");
		wr_reg(RA, 32'hFFED7FFF);
		rd_chk(RA, 32'h0FE169F0);
		wr_reg(32'hE002C018, 32'h0);
		rd_chk(RA, 32'h0FE169F0);
		rd_chk(32'hE002C018, 32'h0);
		$display("test reserved done");
		wr_reg(RA, 32'h00000030);
		@(posedge clock);
		#1;
		chk(32'(pin_dir[15:0]), 32'h00FF);
		wr_reg(RA, 32'h0);
		@(posedge clock);
		#1;
		chk(32'(pin_dir[15:0]), 32'h0000);
		@(posedge clock);
		drive_set <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk(32'(pin_dir[15:0]), 32'h00FF);
		$display("test direction done");
		final_report();
	end
endmodule : tb
